/* File: rtl/sarcc_top.sv */
// SAR converter control: register file, converter clock choice and
// conversion sequencer that captures the front end's digitised level.
// Assumes the analog front end presents a 10-bit level and an over-reference
// flag on pins; these are synchronised here before use.
`timescale 1ns/10ps

module sarcc_top
  import sarcc_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = 2
)
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              osc_tick,
  input  wire logic [RES_W-1:0]  analog_level,
  input  wire logic              analog_over_ref,
  output logic      [3:0]        analog_input_sel,
  output logic                   reference_connect,
  output logic                   sample_hold_on,
  output logic                   converter_busy
);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_CONV   = 3'b010,
    ST_FINISH = 3'b100
  } sarcc_state_t;

  // Register state
  logic [7:0]   ctrl0_q;
  logic [7:0]   ctrl0_d;
  logic [7:0]   ctrl1_q;
  logic [7:0]   ctrl1_d;
  logic [9:0]   result_q;
  logic [9:0]   result_d;
  logic         done_q;
  logic         done_d;
  logic [7:0]   rdata_q;
  logic [7:0]   rdata_d;

  // Sequencer state
  sarcc_state_t state_q;
  sarcc_state_t state_d;
  logic [5:0]   cnt_q;
  logic [5:0]   cnt_d;

  // Front end synchroniser and word hold
  localparam int unsigned FE_W = RES_W + 1;
  logic [FE_W-1:0] fe_sync_q [SYNC_STAGES];
  logic [FE_W-1:0] fe_sync_d [SYNC_STAGES];
  logic [FE_W-1:0] fe_prev_q;
  logic [FE_W-1:0] fe_prev_d;
  logic [FE_W-1:0] fe_hold_q;
  logic [FE_W-1:0] fe_hold_d;

  // Oscillator synchroniser and rising-edge detect
  logic [2:0]   osc_sync_q;
  logic [2:0]   osc_sync_d;
  logic         osc_rise;

  logic         conv_tick;
  logic         wr_ctrl0;
  logic         wr_ctrl1;
  logic         rd_status;
  logic [7:0]   status_word;
  logic         conv_end;
  logic         chan_ok;
  sarcc_ck_t    ck_sel;
  sarcc_sample_t smp;

  function automatic logic [5:0] conv_len(input logic ten_bit, input logic sh_on);
    if (sh_on) begin
      conv_len = ten_bit ? CYC_10B_SH : CYC_8B_SH;
    end else begin
      conv_len = ten_bit ? CYC_10B_NOSH : CYC_8B_NOSH;
    end
  endfunction : conv_len

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
    addr_hit = (addr == offset);
  endfunction : addr_hit

  function automatic logic [3:0] chan_onehot(input logic [1:0] code);
    chan_onehot       = 4'h0;
    chan_onehot[code] = 1'b1;
  endfunction : chan_onehot

  // Level and flag pass the flop chain; each stage is read only by the next one
  always_comb begin
    fe_sync_d[0] = {analog_over_ref, analog_level};
    for (int unsigned k = 1; k < SYNC_STAGES; k++) begin
      fe_sync_d[k] = fe_sync_q[k-1];
    end
  end

  // A multi-bit word can be caught mid-change; keep it only after two equal samples
  always_comb begin
    fe_prev_d = fe_sync_q[SYNC_STAGES-1];
    fe_hold_d = fe_hold_q;
    if (fe_sync_q[SYNC_STAGES-1] == fe_prev_q) begin
      fe_hold_d = fe_prev_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int unsigned k = 0; k < SYNC_STAGES; k++) begin
        fe_sync_q[k] <= '0;
      end
      fe_prev_q <= '0;
      fe_hold_q <= '0;
    end else begin
      fe_sync_q <= fe_sync_d;
      fe_prev_q <= fe_prev_d;
      fe_hold_q <= fe_hold_d;
    end
  end

  // Oscillator comes from its own domain; it must run at under half the mclk rate
  always_comb begin
    osc_sync_d = {osc_sync_q[1:0], osc_tick};
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      osc_sync_q <= 3'h0;
    end else begin
      osc_sync_q <= osc_sync_d;
    end
  end

  assign osc_rise = osc_sync_q[1] && !osc_sync_q[2];

  // Converter clock code: high bit from control one, low bit from control zero
  always_comb begin
    case ({ctrl1_q[C1_CKS_HIGH], ctrl0_q[C0_CKS_LOW]})
      2'b00:   ck_sel = SARCC_CK_DIV4;
      2'b01:   ck_sel = SARCC_CK_DIV2;
      2'b10:   ck_sel = SARCC_CK_DIV1;
      default: ck_sel = SARCC_CK_OSC;
    endcase
  end

  sarcc_clkgen u_clkgen (
    .mclk     (mclk),
    .rst      (rst),
    .sel      (ck_sel),
    .osc_tick (osc_rise),
    .tick     (conv_tick)
  );

  assign wr_ctrl0  = reg_wr && addr_hit(reg_addr, CTRL0_OFFSET);
  assign wr_ctrl1  = reg_wr && addr_hit(reg_addr, CTRL1_OFFSET);
  assign rd_status = reg_rd && addr_hit(reg_addr, STATUS_OFFSET);
  assign chan_ok  = ctrl0_q[C0_GROUP_EN] && ctrl0_q[C0_CH_LSB+2];

  // Channel drive to the analog mux
  always_comb begin
    analog_input_sel = 4'h0;
    if (chan_ok) begin
      analog_input_sel = chan_onehot(ctrl0_q[C0_CH_LSB +: 2]);
    end
  end

  assign reference_connect = ctrl1_q[C1_REF_CONN];
  assign sample_hold_on    = ctrl1_q[C1_SH_EN];
  assign converter_busy    = (state_q != ST_IDLE);

  // Conversion sequencer
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    conv_end = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (ctrl0_q[C0_START] && chan_ok) begin
          state_d = ST_CONV;
          cnt_d   = conv_len(ctrl1_q[C1_RES_SEL], ctrl1_q[C1_SH_EN]);
        end
      end
      ST_CONV: begin
        if (!ctrl0_q[C0_START]) begin
          state_d = ST_IDLE;
        end else if (conv_tick) begin
          if (cnt_q == 6'd1) begin
            state_d = ST_FINISH;
          end else begin
            cnt_d = cnt_q - 6'd1;
          end
        end
      end
      ST_FINISH: begin
        conv_end = ctrl0_q[C0_START];
        state_d  = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 6'd0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Captured sample: end strobe, channel and the held front-end level and flag
  always_comb begin
    smp.valid    = conv_end;
    smp.channel  = ctrl0_q[C0_CH_LSB +: 2];
    smp.level    = fe_hold_q[RES_W-1:0];
    smp.over_ref = fe_hold_q[RES_W];
  end

  // Control zero; a software write beats the one-shot clear, so a restart written in that cycle is kept
  always_comb begin
    ctrl0_d = ctrl0_q;
    if (wr_ctrl0) begin
      ctrl0_d = reg_wdata & CTRL0_WMASK;
    end else if (smp.valid && !ctrl0_q[C0_MODE]) begin
      ctrl0_d[C0_START] = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl0_q <= CTRL0_RESET;
    end else begin
      ctrl0_q <= ctrl0_d;
    end
  end

  // Control one
  always_comb begin
    ctrl1_d = ctrl1_q;
    if (wr_ctrl1) begin
      ctrl1_d = reg_wdata & CTRL1_WMASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl1_q <= CTRL1_RESET;
    end else begin
      ctrl1_q <= ctrl1_d;
    end
  end

  // Result, saturated to the active width
  always_comb begin
    result_d = result_q;
    if (smp.valid) begin
      if (smp.over_ref) begin
        result_d = ctrl1_q[C1_RES_SEL] ? FULL_10B : FULL_8B;
      end else if (ctrl1_q[C1_RES_SEL]) begin
        result_d = smp.level;
      end else begin
        result_d = {2'b00, smp.level[9:2]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      result_q <= 10'h000;
    end else begin
      result_q <= result_d;
    end
  end

  // Done flag; a finishing conversion wins over a status read in the same cycle
  always_comb begin
    done_d = done_q;
    if (rd_status) begin
      done_d = 1'b0;
    end
    if (smp.valid) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  assign status_word = {6'h00, converter_busy, done_q};

  // Read data stand one cycle after the strobe and are zero otherwise
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        CTRL0_OFFSET:  rdata_d = ctrl0_q;
        CTRL1_OFFSET:  rdata_d = ctrl1_q;
        RESLO_OFFSET:  rdata_d = result_q[7:0];
        RESHI_OFFSET:  rdata_d = {6'h00, result_q[9:8]};
        STATUS_OFFSET: rdata_d = status_word;
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : sarcc_top

/* File: rtl/sarcc_pkg.sv */
// Package for the SAR converter control block: register map, field positions,
// reset values, cycle counts and shared types.
// Assumes one 20 MHz clock and a plain address/strobe register port.
package sarcc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RES_W  = 10;

  // Register offsets
  localparam logic [7:0] CTRL0_OFFSET  = 8'hd6;
  localparam logic [7:0] CTRL1_OFFSET  = 8'hd7;
  localparam logic [7:0] RESLO_OFFSET  = 8'hd8;
  localparam logic [7:0] RESHI_OFFSET  = 8'hd9;
  localparam logic [7:0] STATUS_OFFSET = 8'hda;

  // Control zero fields
  localparam int unsigned C0_CH_LSB   = 0;
  localparam int unsigned C0_MODE     = 3;
  localparam int unsigned C0_GROUP_EN = 4;
  localparam int unsigned C0_RSVD     = 5;
  localparam int unsigned C0_START    = 6;
  localparam int unsigned C0_CKS_LOW  = 7;

  // Control one fields
  localparam int unsigned C1_RES_SEL  = 3;
  localparam int unsigned C1_CKS_HIGH = 4;
  localparam int unsigned C1_REF_CONN = 5;
  localparam int unsigned C1_SH_EN    = 6;

  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] CTRL0_WMASK = 8'hdf;
  localparam logic [7:0] CTRL1_WMASK = 8'h78;

  // Conversion lengths in converter-clock cycles
  localparam logic [5:0] CYC_8B_NOSH  = 6'd49;
  localparam logic [5:0] CYC_10B_NOSH = 6'd59;
  localparam logic [5:0] CYC_8B_SH    = 6'd28;
  localparam logic [5:0] CYC_10B_SH   = 6'd33;

  localparam logic [9:0] FULL_10B = 10'h3ff;
  localparam logic [9:0] FULL_8B  = 10'h0ff;

  localparam logic [2:0] CH_FIRST = 3'b100;

  typedef enum logic [1:0] {
    SARCC_CK_DIV4 = 2'b00,
    SARCC_CK_DIV2 = 2'b01,
    SARCC_CK_DIV1 = 2'b10,
    SARCC_CK_OSC  = 2'b11
  } sarcc_ck_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] channel;
    logic [9:0] level;
    logic       over_ref;
  } sarcc_sample_t;

endpackage : sarcc_pkg

/* File: rtl/sarcc_clkgen.sv */
// Converter clock enable generator.
// Assumes the fast oscillator tick is already synchronous to mclk.
`timescale 1ns/10ps
module sarcc_clkgen
  import sarcc_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire sarcc_ck_t sel,
  input  wire logic      osc_tick,
  output logic           tick
);

  logic [1:0] div_q;
  logic [1:0] div_d;

  always_comb begin
    div_d = div_q + 2'd1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_q <= 2'd0;
    end else begin
      div_q <= div_d;
    end
  end

  // One-cycle enable at the chosen rate
  always_comb begin
    case (sel)
      SARCC_CK_DIV4: tick = (div_q == 2'd3);
      SARCC_CK_DIV2: tick = div_q[0];
      SARCC_CK_DIV1: tick = 1'b1;
      SARCC_CK_OSC:  tick = osc_tick;
      default:       tick = 1'b0;
    endcase
  end

endmodule : sarcc_clkgen

/* File: verification/sarcc_chk_sva.sv */
// Port checker for sarcc_top: register port, selects and busy timing.
// Assumes one clock mclk and synchronous reset rst.
`timescale 1ns/10ps
module sarcc_chk
  import sarcc_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [3:0]        analog_input_sel,
  input wire logic              reference_connect,
  input wire logic              sample_hold_on,
  input wire logic              converter_busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic       w0;
  logic       w1;
  logic [9:0] blen_q;
  logic [9:0] blen_d;
  assign w0 = reg_wr && reg_addr == CTRL0_OFFSET;
  assign w1 = reg_wr && reg_addr == CTRL1_OFFSET;
  // Busy length, so aborts can be told from full runs
  always_comb blen_d = converter_busy ? blen_q + 10'h001 : 10'h000;
  always_ff @(posedge mclk) blen_q <= rst ? 10'h000 : blen_d;
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
  property p_rsvd; reg_rd && reg_addr == CTRL0_OFFSET |=> !reg_rdata[5]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_ref; w1 |=> reference_connect == $past(reg_wdata[5]); endproperty
  a_ref: assert property (p_ref) else $error("reference wrong");
  property p_sh; w1 |=> sample_hold_on == $past(reg_wdata[6]); endproperty
  a_sh: assert property (p_sh) else $error("hold wrong");
  property p_sel; w0 && reg_wdata[4] && reg_wdata[2] |=> analog_input_sel == (4'h1 << $past(reg_wdata[1:0]));
  endproperty
  a_sel: assert property (p_sel) else $error("select wrong");
  property p_grp; w0 && !reg_wdata[4] |=> analog_input_sel == 4'h0; endproperty
  a_grp: assert property (p_grp) else $error("group off ignored");
  property p_stop; w0 && !reg_wdata[6] |-> ##[1:2] !converter_busy; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_go; w0 && reg_wdata[6] && reg_wdata[4] && reg_wdata[2] && !converter_busy |-> ##[1:2] converter_busy;
  endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_len; $fell(converter_busy) && !$past(reg_wr) && !$past(reg_wr, 2) && !$past(reg_wr, 3)
    |-> blen_q >= 10'h01b; endproperty
  a_len: assert property (p_len) else $error("run too short");
endmodule : sarcc_chk
bind sarcc_top sarcc_chk u_chk (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .analog_input_sel(analog_input_sel),
  .reference_connect(reference_connect), .sample_hold_on(sample_hold_on), .converter_busy(converter_busy));

/* File: verification/sarcc_analog_model.sv */
// Analog input model: four fixed levels picked by the one-hot select.
// Assumes the bench drives the over-reference line.
`timescale 1ns/10ps
module sarcc_analog_model (
  input  wire logic       mclk,
  input  wire logic [3:0] sel,
  input  wire logic       over,
  output logic      [9:0] level,
  output logic            over_ref
);
  logic [9:0] float_q = 10'h155;
  // Unselected mux wanders, so a stale level cannot pass
  always @(posedge mclk) float_q <= ~float_q;
  always_comb begin
    level = float_q;
    over_ref = float_q[0];
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) begin
        level = 10'h0d3 + 10'(10'h0c1 * k);
        over_ref = over;
      end
    end
  end
endmodule : sarcc_analog_model

/* File: verification/tb_sarcc_top.sv */
// Bench for sarcc_top: register tasks, channel, conversion and mode tests.
// Assumes the analog model file and the bound checker.
`timescale 1ns/10ps
module tb_sarcc_top
  import sarcc_pkg::*;
;
  logic       mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, osc = 1'b0, over = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [9:0] lvl;
  logic [3:0] sel;
  logic       ovr, refc, sh, busy;
  int         bad_count = 0, total_checks = 0, cyc = 0;
  initial forever #25 mclk = ~mclk;
  sarcc_top u_dut (.mclk(mclk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .osc_tick(osc), .analog_level(lvl), .analog_over_ref(ovr), .analog_input_sel(sel),
    .reference_connect(refc), .sample_hold_on(sh), .converter_busy(busy));
  sarcc_analog_model u_ana (.mclk(mclk), .sel(sel), .over(over), .level(lvl), .over_ref(ovr));
  task automatic finish_test();
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Oscillator tick every third cycle; hang cut off well past the longest run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    osc <= (cyc % 3) == 0;
    if (cyc > 30000) begin
      bad_count = bad_count + 1;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(n, {2'b00, e}, {2'b00, rdata});
  endtask : rreg
  task automatic wbusy(input logic v, output int n);
    n = 0;
    #1;
    while (busy !== v && n < 2000) begin
      @(posedge mclk);
      #1;
      n = n + 1;
    end
  endtask : wbusy
  initial begin
    int n, d, e;
    logic [9:0] lv, ex;
    logic ov;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rreg(8'hd6, 8'h00, "ctrl0_rst");
    rreg(8'hd7, 8'h00, "ctrl1_rst");
    wreg(8'hd7, 8'hff);
    rreg(8'hd7, 8'h78, "ctrl1_mask");
    chk("ref_sh", 10'h003, {8'h00, sh, refc});
    wreg(8'hd6, 8'hbf);
    rreg(8'hd6, 8'h9f, "ctrl0_rsvd");
    rreg(8'he0, 8'h00, "unmapped");
    for (int c = 0; c < 5; c++) begin
      wreg(8'hd6, c < 4 ? 8'h14 | c[7:0] : 8'h07);
      @(posedge mclk);
      #1 chk("sel", c < 4 ? 10'(4'h1 << c) : 10'h000, {6'h00, sel});
    end
    for (int i = 0; i < 16; i++) begin
      d = i[1] ? (i[0] ? 3 : 1) : (i[0] ? 2 : 4);
      e = i[3] ? (i[2] ? 33 : 59) : (i[2] ? 28 : 49);
      ov = i[0] ^ i[3];
      lv = 10'h0d3 + 10'(10'h0c1 * i[1:0]);
      ex = ov ? (i[3] ? 10'h3ff : 10'h0ff) : (i[3] ? lv : {2'b00, lv[9:2]});
      over <= ov;
      wreg(8'hd7, {1'b0, i[2], 1'b0, i[1], i[3], 3'b000});
      wreg(8'hd6, {i[0], 5'b10101, i[1:0]});
      wbusy(1'b1, n);
      wbusy(1'b0, n);
      chk("conv_len", 10'h001, {9'h000, n >= e * d - d && n <= e * d + d + 2});
      rreg(8'hd8, ex[7:0], "res_lo");
      rreg(8'hd9, {6'h00, ex[9:8]}, "res_hi");
      rreg(8'hda, 8'h01, "done");
      rreg(8'hd6, {i[0], 5'b00101, i[1:0]}, "start_clr");
    end
    over <= 1'b0;
    wreg(8'hd7, 8'h50);
    wreg(8'hd6, 8'h5c);
    wbusy(1'b1, n);
    wbusy(1'b0, n);
    wbusy(1'b1, n);
    chk("rerun", 10'h001, {9'h000, busy});
    rreg(8'hd6, 8'h5c, "rep_start");
    wreg(8'hd6, 8'h1c);
    wbusy(1'b0, n);
    chk("abort", 10'h001, {9'h000, n <= 2});
    rreg(8'hda, 8'h01, "done_rep");
    repeat (40) @(posedge mclk);
    rreg(8'hda, 8'h00, "no_result");
    finish_test();
  end
endmodule : tb_sarcc_top
